// [sepr_consts.svh]
`ifndef SEPR_CONSTS_SVH
`define SEPR_CONSTS_SVH

// =====================================================
// Device-address byte types and first address-byte selects
`define SEPR_TYPE_ARRAY 4'hA
`define SEPR_TYPE_SPECIAL 4'hB
`define SEPR_SEL_IDPAGE 2'h0
`define SEPR_SEL_PROGADDR 2'h1

// =====================================================
// Write protect register fields and its address-byte select bit
`define SEPR_PROT_LSB 1
`define SEPR_PROT_MSB 3
`define SEPR_WPSEL_BIT 7

// =====================================================
// Factory defaults of nonvolatile state
`define SEPR_BUSADDR_DEFAULT 3'h0
`define SEPR_PROT_DEFAULT 3'h0

// =====================================================
// Sizes
`define SEPR_ARRAY_BYTES 8192
`define SEPR_PAGE_BYTES 32
`define SEPR_FIFO_DEPTH 32

// =====================================================
// Timing
`define SEPR_CLK_PERIOD_NS 10
`define SEPR_T_WR_MS 5
`define SEPR_T_WR_CYCLES ((`SEPR_T_WR_MS * 1000000) / `SEPR_CLK_PERIOD_NS)

`endif

// [sepr_eeprom.sv]
`timescale 1ns/1ps
`include "sepr_consts.svh"

// =====================================================
// Write data buffer
module sepr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `SEPR_FIFO_DEPTH
) (
  // Clock, reset and flush
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_depth_chk
    $error("sepr_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = wr_ptr == rd_ptr;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = store[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_in)
  begin
    if (in_valid_in && !full)
    begin
      store[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in || flush_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid_in && !full)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready_in && !empty)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// =====================================================
// Two-wire EEPROM command logic
module sepr_eeprom #(
  parameter int WR_CYCLES = `SEPR_T_WR_CYCLES
) (
  // Clock and power-on reset
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  // Factory erase of nonvolatile state
  input wire logic NV_CLEAR_IN,
  // Two-wire bus
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  // Status
  output logic BUSY_OUT
);
  if (WR_CYCLES < 2 * `SEPR_FIFO_DEPTH)
  begin : g_wr_chk
    $error("sepr_eeprom write cycle too short to drain the buffer");
  end

  // =====================================================
  // Storage
  logic [7:0] mem [`SEPR_ARRAY_BYTES];
  logic [7:0] idpage [`SEPR_PAGE_BYTES];
  logic [2:0] nv_busaddr;
  sepr_pkg::sepr_prot_t nv_prot;

  // =====================================================
  // Pin synchronisers
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;

  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end
    else
    begin
      scl_s1 <= SCL_IN;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= SDA_IN;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;
  assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_det = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

  // =====================================================
  // Helpers
  function automatic logic is_protected(input logic [12:0] a,
                                        input sepr_pkg::sepr_prot_t p);
    is_protected = p.enable && (a[12:11] >= (2'h3 - {p.bp_high, p.bp_low}));
  endfunction

  function automatic logic [7:0] read_byte(input logic [12:0] a,
                                           input sepr_pkg::sepr_cmd_t c);
    if (c.special)
      read_byte = idpage[a[4:0]];
    else if (c.wp_sel)
      read_byte = {4'h0, nv_prot, 1'b0};
    else
      read_byte = mem[a];
  endfunction

  // =====================================================
  // Bus engine
  sepr_pkg::sepr_state_t state;
  sepr_pkg::sepr_cmd_t cmd;
  sepr_pkg::sepr_wkind_t wkind;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [7:0] addr_hi;
  logic [7:0] wdata;
  logic [12:0] cnt_addr;
  logic [12:0] wr_base;
  logic [5:0] n_data;
  logic ack_flag;
  logic ack_ph;
  logic reject;
  logic busy;
  logic sda_oe;

  logic [7:0] rx_byte;
  logic byte_done;
  logic [12:0] wr_addr;
  logic push_req;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic commit_now;
  logic flush;
  logic dev_match;

  assign rx_byte = {shreg[6:0], sda_s2};
  assign byte_done = (state == sepr_pkg::ST_RX) && scl_rise && (bit_cnt == 4'h7);
  assign wr_addr = {wr_base[12:5], wr_base[4:0] + n_data[4:0]};
  assign dev_match = ((rx_byte[7:4] == `SEPR_TYPE_ARRAY) || (rx_byte[7:4] == `SEPR_TYPE_SPECIAL))
    && (rx_byte[3:1] == nv_busaddr) && !busy;
  assign push_req = byte_done && (byte_idx == 2'h3) && !cmd.rd
    && (cmd.special ? (addr_hi[2:1] == `SEPR_SEL_IDPAGE)
                    : (!cmd.wp_sel && !is_protected(wr_addr, nv_prot)));
  assign commit_now = stop_det && !busy && !cmd.rd && (byte_idx == 2'h3) && !reject
    && (state != sepr_pkg::ST_IDLE || n_data != 6'h0)
    && (((wkind == sepr_pkg::WK_BUSADDR) || (wkind == sepr_pkg::WK_PROTECT))
        ? (n_data == 6'h1) : (n_data != 6'h0));
  assign flush = (start_det || stop_det) && !busy && !commit_now;

  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      state <= sepr_pkg::ST_IDLE;
      cmd <= '0;
      wkind <= sepr_pkg::WK_ARRAY;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      addr_hi <= 8'h00;
      wdata <= 8'h00;
      cnt_addr <= 13'h0000;
      wr_base <= 13'h0000;
      n_data <= 6'h00;
      ack_flag <= 1'b0;
      ack_ph <= 1'b0;
      reject <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (start_det && !busy)
    begin
      state <= sepr_pkg::ST_RX;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      n_data <= 6'h00;
      reject <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (stop_det)
    begin
      state <= sepr_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end
    else
    begin
      unique case (state)
        sepr_pkg::ST_IDLE:
        begin
          sda_oe <= 1'b0;
        end
        sepr_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            shreg <= rx_byte;
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done)
          begin
            state <= sepr_pkg::ST_ACK;
            ack_ph <= 1'b0;
            ack_flag <= 1'b1;
            unique case (byte_idx)
              2'h0:
              begin
                cmd.rd <= rx_byte[0];
                cmd.special <= rx_byte[4];
                ack_flag <= dev_match;
                if (rx_byte[0])
                begin
                  tx <= read_byte(cnt_addr, '{rx_byte[4], 1'b1, cmd.wp_sel});
                  if (rx_byte[4] || !cmd.wp_sel)
                  begin
                    cnt_addr <= cnt_addr + 13'h1;
                  end
                end
                byte_idx <= 2'h1;
              end
              2'h1:
              begin
                addr_hi <= rx_byte;
                cmd.wp_sel <= rx_byte[`SEPR_WPSEL_BIT];
                byte_idx <= 2'h2;
              end
              2'h2:
              begin
                cnt_addr <= {addr_hi[4:0], rx_byte};
                wr_base <= {addr_hi[4:0], rx_byte};
                byte_idx <= 2'h3;
              end
              default:
              begin
                wdata <= rx_byte;
                if (cmd.special && addr_hi[2:1] == `SEPR_SEL_PROGADDR)
                begin
                  wkind <= sepr_pkg::WK_BUSADDR;
                  n_data <= n_data + 6'h1;
                end
                else if (cmd.special)
                begin
                  wkind <= sepr_pkg::WK_IDPAGE;
                  ack_flag <= push_req && fifo_in_ready;
                  reject <= !(push_req && fifo_in_ready);
                  n_data <= n_data + 6'h1;
                end
                else if (cmd.wp_sel)
                begin
                  wkind <= sepr_pkg::WK_PROTECT;
                  n_data <= n_data + 6'h1;
                end
                else
                begin
                  wkind <= sepr_pkg::WK_ARRAY;
                  ack_flag <= push_req && fifo_in_ready;
                  reject <= !(push_req && fifo_in_ready);
                  n_data <= n_data + 6'h1;
                  cnt_addr <= {wr_addr[12:5], wr_addr[4:0] + 5'h1};
                end
              end
            endcase
          end
        end
        sepr_pkg::ST_ACK:
        begin
          if (scl_fall && !ack_ph)
          begin
            sda_oe <= ack_flag;
            ack_ph <= 1'b1;
            if (!ack_flag)
            begin
              state <= sepr_pkg::ST_IDLE;
            end
          end
          else if (scl_fall)
          begin
            if (cmd.rd)
            begin
              sda_oe <= !tx[7];
              tx <= {tx[6:0], 1'b0};
              bit_cnt <= 4'h1;
              state <= sepr_pkg::ST_TX;
            end
            else
            begin
              sda_oe <= 1'b0;
              bit_cnt <= 4'h0;
              state <= sepr_pkg::ST_RX;
            end
          end
        end
        sepr_pkg::ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == 4'h8)
            begin
              sda_oe <= 1'b0;
              state <= sepr_pkg::ST_RACK;
            end
            else
            begin
              sda_oe <= !tx[7];
              tx <= {tx[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        sepr_pkg::ST_RACK:
        begin
          if (scl_rise && !sda_s2)
          begin
            tx <= read_byte(cnt_addr, cmd);
            if (cmd.special || !cmd.wp_sel)
            begin
              cnt_addr <= cnt_addr + 13'h1;
            end
            ack_ph <= 1'b1;
            state <= sepr_pkg::ST_ACK;
          end
          else if (scl_rise)
          begin
            state <= sepr_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state <= sepr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // =====================================================
  // Data buffer
  sepr_fifo #(
    .WIDTH(8),
    .DEPTH(`SEPR_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(MCLK_IN),
    .rst_in(RESET_IN),
    .flush_in(flush),
    .in_valid_in(push_req),
    .in_ready_out(fifo_in_ready),
    .in_data_in(rx_byte),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(busy),
    .out_data_out(fifo_out_data)
  );

  // =====================================================
  // Self-timed write cycle
  logic [$clog2(WR_CYCLES+1)-1:0] timer;
  logic [12:0] drain_addr;
  logic wr_done;

  assign wr_done = busy && (timer == '0);

  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      busy <= 1'b0;
      timer <= '0;
      drain_addr <= 13'h0000;
    end
    else if (commit_now)
    begin
      busy <= 1'b1;
      timer <= $bits(timer)'(WR_CYCLES - 1);
      drain_addr <= wr_base;
    end
    else if (busy)
    begin
      timer <= timer - 1'b1;
      busy <= !wr_done;
      if (fifo_out_valid)
      begin
        drain_addr <= {drain_addr[12:5], drain_addr[4:0] + 5'h1};
      end
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (busy && fifo_out_valid && wkind == sepr_pkg::WK_ARRAY)
    begin
      mem[drain_addr] <= fifo_out_data;
    end
    if (busy && fifo_out_valid && wkind == sepr_pkg::WK_IDPAGE)
    begin
      idpage[drain_addr[4:0]] <= fifo_out_data;
    end
  end

  // Nonvolatile cells survive power-on reset
  always_ff @(posedge MCLK_IN)
  begin
    if (NV_CLEAR_IN)
    begin
      nv_busaddr <= `SEPR_BUSADDR_DEFAULT;
      nv_prot <= `SEPR_PROT_DEFAULT;
    end
    else if (wr_done && wkind == sepr_pkg::WK_BUSADDR)
    begin
      nv_busaddr <= wdata[2:0];
    end
    else if (wr_done && wkind == sepr_pkg::WK_PROTECT)
    begin
      nv_prot <= wdata[`SEPR_PROT_MSB:`SEPR_PROT_LSB];
    end
  end

  // =====================================================
  // Outputs
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      SDA_OUT <= 1'b0;
      SDA_OE_OUT <= 1'b0;
      BUSY_OUT <= 1'b0;
    end
    else
    begin
      SDA_OUT <= 1'b0;
      SDA_OE_OUT <= sda_oe;
      BUSY_OUT <= busy;
    end
  end
endmodule

// [sepr_eeprom_monitor.sv]
`timescale 1ns/1ps
// ==========
// Pin-level checks
module sepr_eeprom_monitor #(
  parameter int WR_CYCLES = 400
) (
  // Watched ports
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  input wire logic NV_CLEAR_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT,
  input wire logic BUSY_OUT
);
  localparam int WR_LO = WR_CYCLES - 2;
  localparam int WR_HI = WR_CYCLES + 2;
  int busy_len;
  logic [7:0] since_stop;
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RESET_IN);
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN || !BUSY_OUT)
      busy_len <= 0;
    else
      busy_len <= busy_len + 1;
  end
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
      since_stop <= 8'hFF;
    else if (SCL_IN && $rose(SDA_IN))
      since_stop <= 8'h00;
    else if (since_stop != 8'hFF)
      since_stop <= since_stop + 8'h01;
  end
  sequence s_stop;
    SCL_IN && $rose(SDA_IN);
  endsequence
  sequence s_start;
    SCL_IN && $fell(SDA_IN);
  endsequence
  property p_reset_quiet;
    $fell(RESET_IN) |-> !SDA_OE_OUT && !BUSY_OUT;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
  property p_open_drain;
    SDA_OUT == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  property p_busy_quiet;
    BUSY_OUT |-> !SDA_OE_OUT;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
  property p_busy_len;
    $fell(BUSY_OUT) |-> busy_len inside {[WR_LO:WR_HI]};
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write time wrong");
  property p_busy_min;
    $rose(BUSY_OUT) |=> BUSY_OUT [*8];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_busy_cause;
    $rose(BUSY_OUT) |-> since_stop < 8'h08;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("write without stop");
  property p_oe_phase;
    $changed(SDA_OE_OUT) |-> !SCL_IN && !$past(SCL_IN, 2);
  endproperty
  a_oe_phase: assert property (p_oe_phase) else $error("drive change off clock low");
  property p_stop_quiet;
    s_stop |=> !SDA_OE_OUT [*8];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("drive after stop");
  property p_start_quiet;
    s_start |=> !SDA_OE_OUT [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("drive after start");
endmodule

bind sepr_eeprom sepr_eeprom_monitor #(.WR_CYCLES(WR_CYCLES)) mon_u (
  .MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .NV_CLEAR_IN(NV_CLEAR_IN),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE_OUT(SDA_OE_OUT), .BUSY_OUT(BUSY_OUT)
);

// [sepr_eeprom_tb.sv]
`timescale 1ns/1ps
`include "sepr_consts.svh"
module sepr_eeprom_tb;
  localparam int WR = 400;
  localparam int STARTUP_WAIT = 10000;
  localparam logic [3:0] TA = `SEPR_TYPE_ARRAY;
  localparam logic [3:0] TS = `SEPR_TYPE_SPECIAL;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic nv_clr = 1'b1;
  logic scl, host_low, sda, rv, sda_out, sda_oe, busy;
  logic [8:0] res;
  logic [8:0] exp_q[$];
  logic [31:0] seed = 32'h3978;
  logic [2:0] ba = 3'h0;
  logic [7:0] d0, d1, pv;
  logic [15:0] base;
  int fail_count = 0;
  int n_checks = 0;
  always #5 mclk = ~mclk;
  assign sda = ~(host_low | sda_oe);
  sepr_eeprom #(.WR_CYCLES(WR)) dut_u (
    .MCLK_IN(mclk), .RESET_IN(rst), .NV_CLEAR_IN(nv_clr), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe), .BUSY_OUT(busy)
  );
  sepr_host_model host_u (
    .clk_in(mclk), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low),
    .res_valid_out(rv), .res_out(res)
  );
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  task chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test();
    if (exp_q.size() != 0)
      fail_count++;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========
  // Result watcher
  always @(posedge mclk)
  begin
    if (rv === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(res, ~res);
      else
        chk(res, exp_q.pop_front());
    end
  end
  task wr(input logic [7:0] d, input logic nak);
    exp_q.push_back({1'b1, 7'h00, nak});
    host_u.wbyte(d, 1'b1);
  endtask
  task rd(input logic [7:0] e, input logic more);
    exp_q.push_back({1'b0, e});
    host_u.rbyte(more);
  endtask
  task set_addr(input logic [3:0] ty, input logic [15:0] a);
    host_u.start();
    wr({ty, ba, 1'b0}, 1'b0);
    wr(a[15:8], 1'b0);
    wr(a[7:0], 1'b0);
  endtask
  task wait_idle();
    for (int i = 0; i < WR + 100 && busy !== 1'b0; i++)
      @(posedge mclk);
    if (busy !== 1'b0)
    begin
      chk({8'h00, busy}, 9'h000);
      stop_test();
    end
  endtask
  task wr_byte(input logic [3:0] ty, input logic [15:0] a, input logic [7:0] d, input logic nak);
    set_addr(ty, a);
    wr(d, nak);
    host_u.stop();
    repeat (4) @(posedge mclk);
    chk({8'h00, busy}, {8'h00, ~nak});
    if (!nak)
    begin
      host_u.start();
      wr({TA, ba, 1'b0}, 1'b1);
      host_u.stop();
    end
    wait_idle();
  endtask
  task rd_from(input logic [3:0] ty, input logic [15:0] a, input logic [7:0] e0, e1);
    set_addr(ty, a);
    host_u.start();
    wr({ty, ba, 1'b1}, 1'b0);
    rd(e0, 1'b1);
    rd(e1, 1'b0);
    host_u.stop();
    repeat (4) @(posedge mclk);
    chk({8'h00, busy}, 9'h000);
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    nv_clr <= 1'b0;
    repeat (STARTUP_WAIT) @(posedge mclk);
    d0 = 8'(rnd());
    d1 = 8'(rnd());
    wr_byte(TA, 16'h1FFF, d0, 1'b0);
    wr_byte(TA, 16'h0000, d1, 1'b0);
    rd_from(TA, 16'h1FFF, d0, d1);
    $display("test array done");
    wr_byte(TS, 16'h0005 | (rnd() & 16'h79E0), d1, 1'b0);
    wr_byte(TS, 16'h0006, d0, 1'b0);
    rd_from(TS, 16'h0005 | (rnd() & 16'h79E0), d1, d0);
    $display("test id page done");
    for (int bp = 0; bp < 4; bp++)
    begin
      pv = {4'h0, 1'b1, 2'(bp), 1'b0};
      base = 16'h1800 - 16'(bp) * 16'h0800;
      wr_byte(TA, 16'h8000 | (rnd() & 16'h7FFF), pv | (8'(rnd()) & 8'hF1), 1'b0);
      rd_from(TA, 16'hFFFF, pv, pv);
      wr_byte(TA, base, 8'(rnd()), 1'b1);
      if (bp < 3)
        wr_byte(TA, base - 16'h0001, 8'(rnd()), 1'b0);
    end
    rd_from(TA, 16'h1FFF, d0, d1);
    $display("test protect done");
    set_addr(TA, 16'h8000);
    wr(8'h02, 1'b0);
    host_u.wbyte(8'h04, 1'b0);
    host_u.stop();
    repeat (4) @(posedge mclk);
    chk({8'h00, busy}, 9'h000);
    rd_from(TA, 16'h8000, 8'h0E, 8'h0E);
    wr_byte(TA, 16'h8000, 8'h06, 1'b0);
    wr_byte(TA, 16'h0000, d0, 1'b0);
    $display("test protect discard done");
    wr_byte(TS, (rnd() & 16'hF9FF) | 16'h0200, {5'(rnd()), 3'h5}, 1'b0);
    host_u.start();
    wr({TA, ba, 1'b0}, 1'b1);
    host_u.stop();
    ba = 3'h5;
    rd_from(TA, 16'h1FFF, d0, d0);
    $display("test bus address done");
    stop_test();
  end
endmodule

// [sepr_host_model.sv]
`timescale 1ns/1ps
// ==========
// Two-wire bus controller
module sepr_host_model (
  // Clock
  input wire logic clk_in,
  // Bus
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out,
  // Results
  output logic res_valid_out,
  output logic [8:0] res_out
);
  logic s;
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    res_valid_out = 1'b0;
    res_out = 9'h000;
  end
  task tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // One 80 ns clock period: six cycles low so the device answer settles before
  // the rise, two high; a change at mid-high makes START or STOP
  task bitc(input logic b, input logic mid, input logic low, output logic v);
    tick(2);
    sda_low_out <= ~b;
    tick(4);
    scl_out <= 1'b1;
    tick(1);
    v = sda_in;
    if (mid)
      sda_low_out <= low;
    tick(1);
    if (!(mid && !low))
      scl_out <= 1'b0;
  endtask
  task start();
    bitc(1'b1, 1'b1, 1'b1, s);
  endtask
  task stop();
    bitc(1'b0, 1'b1, 1'b0, s);
  endtask
  task report(input logic [8:0] r);
    res_out <= r;
    res_valid_out <= 1'b1;
    tick(1);
    res_valid_out <= 1'b0;
  endtask
  task wbyte(input logic [7:0] d, input logic rep);
    logic a;
    for (int i = 7; i >= 0; i--)
      bitc(d[i], 1'b0, 1'b0, s);
    bitc(1'b1, 1'b0, 1'b0, a);
    if (rep)
      report({1'b1, 7'h00, a});
  endtask
  task rbyte(input logic more);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--)
      bitc(1'b1, 1'b0, 1'b0, d[i]);
    bitc(~more, 1'b0, 1'b0, s);
    report({1'b0, d});
  endtask
endmodule

// [sepr_pkg.sv]
package sepr_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} sepr_state_t;

  typedef enum logic [1:0] {WK_ARRAY, WK_IDPAGE, WK_BUSADDR, WK_PROTECT} sepr_wkind_t;

  typedef struct packed {
    logic enable;
    logic bp_high;
    logic bp_low;
  } sepr_prot_t;

  typedef struct packed {
    logic special;
    logic rd;
    logic wp_sel;
  } sepr_cmd_t;

endpackage
